// ==== include/pdg_pkg.sv ====
// Shared constants and types for the power-down and general-output control block
package pdg_pkg;
  // Host I/O ports of the power controller
  localparam logic [11:0] FLAG_PORT = 12'h226;
  localparam logic [11:0] CTRL_PORT = 12'h227;
  localparam logic [11:0] AUDIO_BASE_DEF = 12'h220;
  localparam logic [11:0] FM_BASE_DEF = 12'h388;
  localparam int AUDIO_SPAN = 16;
  localparam int FM_SPAN = 4;
  // Indirect commands written to the control port
  localparam logic [7:0] CMD_OPD_WR = 8'hcf;
  localparam logic [7:0] CMD_OPD_RD = 8'hce;
  // Control port fields
  localparam int CTRL_PD_REQ = 2;
  localparam int CTRL_PARTIAL = 3;
  localparam int CTRL_OSC_EN = 4;
  localparam int CTRL_GPO_A = 6;
  localparam int CTRL_GPO_B = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Output power-down control fields
  localparam int OPD_DLY_LSB = 0;
  localparam int OPD_INV_A = 4;
  localparam int OPD_TIMED_A = 5;
  localparam int OPD_INV_B = 6;
  localparam int OPD_TIMED_B = 7;
  localparam logic [7:0] OPD_MASK = 8'hf7;
  localparam logic [7:0] OPD_RESET = 8'h00;
  // Activity flag positions in the flag port
  localparam int FLG_SERIAL = 4;
  localparam int FLG_AUDIO = 5;
  localparam int FLG_A45 = 6;
  localparam int FLG_OTHER = 7;
  localparam int FLG_UP = 3;
  // Restore timing: a 16 Hz step from the 50 MHz clock
  localparam int SYS_CLK_HZ = 50000000;
  localparam int RESTORE_TICK_HZ = 16;
  localparam int RESTORE_TICK_CYCLES = SYS_CLK_HZ / RESTORE_TICK_HZ;
  // Power states, Gray coded along up -> partial -> full
  typedef enum logic [1:0] {
    PS_UP = 2'b00,
    PS_PARTIAL = 2'b01,
    PS_FULL = 2'b11
  } pdg_pstate_t;
endpackage

// ==== design/pdg_tick_div.sv ====
// Divider producing the one-cycle 16 Hz restore step enable
`timescale 1ns/100ps
module pdg_tick_div
  import pdg_pkg::*;
#(
  parameter int DIV = RESTORE_TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Step enable
  output logic tick_o
);
  localparam int CW = $clog2(DIV);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } pdg_div_st_t;
  pdg_div_st_t q, s;

  generate
    if (DIV < 2) begin : g_bad
      $error("pdg_tick_div: DIV must be at least 2");
    end
  endgenerate

  // Free-running count, pulse on wrap
  always_comb begin
    s = q;
    s.tick = 1'b0;
    if (q.cnt == CW'(DIV - 1)) begin
      s.cnt = '0;
      s.tick = 1'b1;
    end else begin
      s.cnt = q.cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  assign tick_o = q.tick;
endmodule

// ==== design/pdg_gpo_restore.sv ====
// One general output: inversion while powered down and timed restore
`timescale 1ns/100ps
module pdg_gpo_restore
  import pdg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Controls
  input wire logic tick_i,
  input wire logic pd_i,
  input wire logic inv_en_i,
  input wire logic timed_en_i,
  input wire logic [2:0] delay_i,
  input wire logic normal_i,
  // Pin level
  output logic gpo_o
);
  typedef struct packed {
    logic pd_d;
    logic pend;
    logic [2:0] cnt;
    logic gpo;
  } pdg_gpo_st_t;
  pdg_gpo_st_t q, s;
  logic wake;

  always_comb begin
    s = q;
    s.pd_d = pd_i;
    wake = q.pd_d && !pd_i;
    if (wake) begin
      s.pend = inv_en_i && timed_en_i;
      s.cnt = 3'h0;
    end else if (q.pend && tick_i) begin
      if (q.cnt == delay_i) begin
        s.pend = 1'b0;
      end else begin
        s.cnt = q.cnt + 3'h1;
      end
    end
    s.gpo = normal_i ^ (inv_en_i && (pd_i || s.pend));
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  assign gpo_o = q.gpo;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  inv_down_a: assert property (pd_i && inv_en_i |=> gpo_o == !$past(normal_i))
    else $error("output not inverted while down");
  no_inv_a: assert property (!inv_en_i |=> gpo_o == $past(normal_i))
    else $error("output left its normal level");
  quick_restore_a: assert property (wake && !timed_en_i |=> gpo_o == $past(normal_i))
    else $error("immediate restore missed");
  timed_start_a: assert property (wake && timed_en_i && inv_en_i |=> q.pend && q.cnt == 3'h0)
    else $error("restore count did not restart");
  // A fresh wake restarts the count, so it is kept out of both checks
  timed_end_a: assert property (q.pend && tick_i && q.cnt == delay_i && !pd_i && !wake |=> !q.pend)
    else $error("restore did not end at match");
  hold_pend_a: assert property (q.pend && !tick_i && !pd_i && !wake |=> q.pend && $stable(q.cnt))
    else $error("restore moved without a step");
  restore_done_c: cover property (q.pend ##1 !q.pend);
endmodule

// ==== design/pdg_power_ctrl.sv ====
// Power-down sequencing, activity flags and general output control
`timescale 1ns/100ps
module pdg_power_ctrl
  import pdg_pkg::*;
#(
  parameter logic [11:0] AUDIO_BASE = AUDIO_BASE_DEF,
  parameter logic [11:0] FM_BASE = FM_BASE_DEF,
  parameter int TICK_CYCLES = RESTORE_TICK_CYCLES
) (
  // Clock and resets
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  // Host I/O cycle
  input wire logic [11:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Activity sources
  input wire logic dack_i,
  input wire logic other_act_i,
  input wire logic serial_act_i,
  // Clock source strap pin, high for crystal
  input wire logic xtal_sel_i,
  // Power controls
  output logic powered_down_state_o,
  output logic partial_pd_o,
  output logic analog_pd_o,
  output logic osc_en_o,
  output logic synth_mute_o,
  output logic audio_en_o,
  output logic synth_en_o,
  output logic periph_en_o,
  // General outputs
  output logic general_output_a_o,
  output logic general_output_b_o
);
  typedef struct packed {
    logic xs1;
    logic xs2;
    pdg_pstate_t st;
    logic [7:0] ctrl;
    logic [7:0] opd;
    logic [3:0] flags;
    logic wr_arm;
    logic rd_arm;
    logic [7:0] rdata;
  } pdg_main_st_t;
  pdg_main_st_t q, s;

  logic acc;
  logic aud_hit;
  logic fm_hit;
  logic [3:0] off;
  logic ctrl_wr;
  logic ctrl_rd;
  logic flag_rd;
  logic pd_edge;
  logic flag_audio;
  logic wake_part;
  logic wake_full;
  logic full_pd;
  logic tick;

  generate
    if (AUDIO_BASE[3:0] != 4'h0 || FM_BASE[1:0] != 2'b00) begin : g_bad_base
      $error("pdg_power_ctrl: port bases must be aligned to their span");
    end
  endgenerate

  // Address window test used for both decoded port groups
  function automatic logic in_win(input logic [11:0] a, input logic [11:0] base, input int span);
    logic [12:0] top;
    top = {1'b0, base} + 13'(span);
    return ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < top);
  endfunction

  // Address decode of the current host cycle
  always_comb begin
    acc = io_rd_i || io_wr_i;
    aud_hit = acc && in_win(io_addr_i, AUDIO_BASE, AUDIO_SPAN);
    fm_hit = acc && in_win(io_addr_i, FM_BASE, FM_SPAN);
    off = io_addr_i[3:0];
    ctrl_wr = io_wr_i && io_addr_i == CTRL_PORT;
    ctrl_rd = io_rd_i && io_addr_i == CTRL_PORT;
    flag_rd = io_rd_i && io_addr_i == FLAG_PORT;
  end

  // Wake and flag sources
  always_comb begin
    // Audio traffic except the mixer pair, status read and offset 7
    flag_audio = (aud_hit && off != 4'h4 && off != 4'h5 && off != 4'h7 && !(off == 4'h6 && io_rd_i))
                 || fm_hit || dack_i;
    wake_part = (aud_hit && off[3:2] != 2'b01) || fm_hit || dack_i;
    // all but the two control ports
    wake_full = ((aud_hit || fm_hit) && io_addr_i != FLAG_PORT && io_addr_i != CTRL_PORT)
                || dack_i || other_act_i;
  end

  // Next-state logic for the whole controller
  always_comb begin
    s = q;
    pd_edge = 1'b0;
    // Strap pin crosses in through two flops
    s.xs1 = xtal_sel_i;
    s.xs2 = q.xs1;

    // flags clear on read, new activity wins
    if (flag_rd) begin
      s.flags = 4'h0;
    end
    if (serial_act_i) begin
      s.flags[FLG_SERIAL - 4] = 1'b1;
    end
    if (flag_audio) begin
      s.flags[FLG_AUDIO - 4] = 1'b1;
    end
    if (aud_hit && (off == 4'h4 || off == 4'h5)) begin
      s.flags[FLG_A45 - 4] = 1'b1;
    end
    if (other_act_i) begin
      s.flags[FLG_OTHER - 4] = 1'b1;
    end

    // indirect write and read of the output register
    if (ctrl_wr) begin
      if (q.wr_arm) begin
        s.opd = io_wdata_i & OPD_MASK;
        s.wr_arm = 1'b0;
      end else if (io_wdata_i == CMD_OPD_WR) begin
        s.wr_arm = 1'b1;
      end else if (io_wdata_i == CMD_OPD_RD) begin
        s.rd_arm = 1'b1;
      end else begin
        s.ctrl = io_wdata_i;
        pd_edge = !q.ctrl[CTRL_PD_REQ] && io_wdata_i[CTRL_PD_REQ];
      end
    end

    // Read data is held until the next read or a soft reset
    if (io_rd_i) begin
      if (flag_rd) begin
        s.rdata = {q.flags, q.st == PS_UP, 3'b000};
      end else if (ctrl_rd) begin
        s.rdata = q.rd_arm ? q.opd : q.ctrl;
        s.rd_arm = 1'b0;
      end else begin
        s.rdata = 8'h00;
      end
    end

    // Power state sequencing
    unique case (q.st)
      PS_UP: begin
        // bit 3 picks partial or full
        if (pd_edge) begin
          s.st = s.ctrl[CTRL_PARTIAL] ? PS_PARTIAL : PS_FULL;
        end
      end
      PS_PARTIAL: begin
        // partial wakes with either clock source
        if (pd_edge && !s.ctrl[CTRL_PARTIAL]) begin
          s.st = PS_FULL;
        end else if (wake_part) begin
          s.st = PS_UP;
        end
      end
      PS_FULL: begin
        // instant wake with an oscillator clock
        // crystal has no auto wake, host restarts it
        if (wake_full && !q.xs2) begin
          s.st = PS_UP;
        end
      end
      default: begin
        s.st = PS_UP;
      end
    endcase

    // soft reset leaves the output register alone
    if (soft_rst_i) begin
      s.st = PS_UP;
      s.ctrl = CTRL_RESET;
      s.flags = 4'h0;
      s.wr_arm = 1'b0;
      s.rd_arm = 1'b0;
      s.rdata = 8'h00;
    end
  end

  // hardware reset clears the output register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{xs1: 1'b0, xs2: 1'b0, st: PS_UP, ctrl: CTRL_RESET, opd: OPD_RESET,
             flags: 4'h0, wr_arm: 1'b0, rd_arm: 1'b0, rdata: 8'h00};
    end else begin
      q <= s;
    end
  end

  // only full power-down drives the inversion
  assign full_pd = q.st == PS_FULL;

  // Power controls decoded from the state register
  // analog and oscillator stay on in partial
  // synth and wave muted in partial
  // peripherals run in partial, audio and synth off
  assign powered_down_state_o = full_pd;
  assign partial_pd_o = q.st == PS_PARTIAL;
  assign analog_pd_o = full_pd;
  // Crystal restart needs the oscillator forced on while down
  assign osc_en_o = !full_pd || q.ctrl[CTRL_OSC_EN];
  assign synth_mute_o = q.st != PS_UP;
  assign audio_en_o = q.st == PS_UP;
  assign synth_en_o = q.st == PS_UP;
  assign periph_en_o = !full_pd;
  assign io_rdata_o = q.rdata;

  // Shared restore step, about 62.5 ms per count
  pdg_tick_div #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // normal levels from control bits 6 and 7
  pdg_gpo_restore u_gpo_a (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .pd_i(full_pd),
    .inv_en_i(q.opd[OPD_INV_A]),
    .timed_en_i(q.opd[OPD_TIMED_A]),
    .delay_i(q.opd[OPD_DLY_LSB +: 3]),
    .normal_i(q.ctrl[CTRL_GPO_A]),
    .gpo_o(general_output_a_o)
  );

  pdg_gpo_restore u_gpo_b (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .pd_i(full_pd),
    .inv_en_i(q.opd[OPD_INV_B]),
    .timed_en_i(q.opd[OPD_TIMED_B]),
    .delay_i(q.opd[OPD_DLY_LSB +: 3]),
    .normal_i(q.ctrl[CTRL_GPO_B]),
    .gpo_o(general_output_b_o)
  );

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  opd_write_a: assert property (q.wr_arm && ctrl_wr && !soft_rst_i |=> q.opd == ($past(io_wdata_i) & OPD_MASK))
    else $error("indirect write not stored");
  // An armed data write in the same cycle still lands, so it is excluded
  soft_keep_a: assert property (soft_rst_i && !(q.wr_arm && ctrl_wr) |=> $stable(q.opd) && q.st == PS_UP)
    else $error("soft reset disturbed output register");
  req_full_a: assert property (q.st == PS_UP && pd_edge && !io_wdata_i[CTRL_PARTIAL] && !soft_rst_i
                               |=> powered_down_state_o)
    else $error("full power-down request ignored");
  req_part_a: assert property (q.st == PS_UP && pd_edge && io_wdata_i[CTRL_PARTIAL] && !soft_rst_i
                               |=> partial_pd_o && !analog_pd_o && osc_en_o)
    else $error("partial power-down not entered");
  part_mute_a: assert property (partial_pd_o |-> synth_mute_o && !audio_en_o && periph_en_o)
    else $error("partial power-down outputs wrong");
  full_wake_a: assert property (full_pd && wake_full && !q.xs2 |=> audio_en_o)
    else $error("no wake from full power-down");
  xtal_hold_a: assert property (full_pd && q.xs2 && !soft_rst_i |=> full_pd)
    else $error("crystal clock woke from full power-down");
  part_skip_a: assert property (partial_pd_o && !wake_part && !pd_edge && !soft_rst_i |=> partial_pd_o)
    else $error("partial power-down left without cause");
  flag_set_a: assert property (other_act_i && !soft_rst_i |=> q.flags[FLG_OTHER - 4])
    else $error("activity flag not set");
  // Pin lags the register by one cycle, so the feature must have been off then too
  reset_out_a: assert property (q.opd == OPD_RESET && $past(q.opd) == OPD_RESET
                                |-> general_output_a_o == $past(q.ctrl[CTRL_GPO_A]))
    else $error("output moved with feature disabled");

  partial_entry_c: cover property (q.st == PS_UP ##1 q.st == PS_PARTIAL ##[1:20] q.st == PS_UP);
  full_entry_c: cover property (q.st == PS_UP ##1 q.st == PS_FULL);
  full_wake_c: cover property (q.st == PS_FULL ##1 q.st == PS_UP);
endmodule

// ==== verification/pdg_power_ctrl_bench.sv ====
// Self-checking bench for the power-down and general-output controller
`timescale 1ns/100ps
module pdg_power_ctrl_bench
  import pdg_pkg::*;
();
  // Short restore step keeps the timed restore within a few dozen cycles
  localparam int TICKS = 8;
  // Design inputs, all valued at time zero
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic soft_rst_i = 1'b0;
  logic [11:0] io_addr_i = 12'h000;
  logic io_rd_i = 1'b0;
  logic io_wr_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [2:0] act = 3'h0; // Bit 2 dma ack, bit 1 other, bit 0 serial
  logic xtal_sel_i = 1'b0;
  // Design outputs
  logic [7:0] io_rdata_o;
  logic powered_down_state_o, partial_pd_o, analog_pd_o, osc_en_o;
  logic synth_mute_o, audio_en_o, synth_en_o, periph_en_o;
  logic general_output_a_o, general_output_b_o;
  logic [7:0] st;
  logic [1:0] gpo;
  int n_errors = 0;
  int num_checks = 0;
  int n;

  pdg_power_ctrl #(
    .AUDIO_BASE(AUDIO_BASE_DEF),
    .FM_BASE(FM_BASE_DEF),
    .TICK_CYCLES(TICKS)
  ) i_dut (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .soft_rst_i(soft_rst_i),
    .io_addr_i(io_addr_i),
    .io_rd_i(io_rd_i),
    .io_wr_i(io_wr_i),
    .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o),
    .dack_i(act[2]),
    .other_act_i(act[1]),
    .serial_act_i(act[0]),
    .xtal_sel_i(xtal_sel_i),
    .powered_down_state_o(powered_down_state_o),
    .partial_pd_o(partial_pd_o),
    .analog_pd_o(analog_pd_o),
    .osc_en_o(osc_en_o),
    .synth_mute_o(synth_mute_o),
    .audio_en_o(audio_en_o),
    .synth_en_o(synth_en_o),
    .periph_en_o(periph_en_o),
    .general_output_a_o(general_output_a_o),
    .general_output_b_o(general_output_b_o)
  );

  // Power outputs packed so one compare covers the whole state
  assign st = {powered_down_state_o, partial_pd_o, analog_pd_o, osc_en_o,
               synth_mute_o, audio_en_o, synth_en_o, periph_en_o};
  assign gpo = {general_output_b_o, general_output_a_o};

  // 50 MHz clock
  always #10 sys_clk_i = ~sys_clk_i;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One host write, strobe high for exactly one sampled edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    io_addr_i <= a;
    io_wdata_i <= d;
    io_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    io_wr_i <= 1'b0;
  endtask

  // One host read; data is registered at the sampling edge
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    io_addr_i <= a;
    io_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    io_rd_i <= 1'b0;
    #1;
    chk("read data", exp, io_rdata_o);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic pulse(input int i);
    @(posedge sys_clk_i);
    act[i] <= 1'b1;
    @(posedge sys_clk_i);
    act[i] <= 1'b0;
  endtask

  // Indirect read: arm with the read command, then read the control port
  task automatic rd_opd(input logic [7:0] exp);
    wr(CTRL_PORT, CMD_OPD_RD);
    rd(CTRL_PORT, exp);
  endtask

  // Pins lag a write by two edges, so wait three before looking
  task automatic chk_st(input logic [7:0] s, input logic [1:0] g);
    settle(3);
    chk("power state", s, st);
    chk("general outputs", {6'h00, g}, {6'h00, gpo});
  endtask

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    n_errors++;
    $display("MISMATCH watchdog expected done seen timeout");
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk_st(8'h17, 2'b00);
    rd_opd(OPD_RESET);
    wr(CTRL_PORT, 8'hc0);
    chk_st(8'h17, 2'b11);
    wr(CTRL_PORT, CMD_OPD_WR);
    wr(CTRL_PORT, 8'h7a);
    rd_opd(8'h72);
    chk_st(8'h17, 2'b11);
    // Full power-down with invert on both, timed restore on output A
    wr(CTRL_PORT, 8'hc4);
    chk_st(8'ha8, 2'b00);
    wr(CTRL_PORT, 8'hc0);
    rd(FLAG_PORT, 8'h00);
    chk_st(8'ha8, 2'b00);
    rd(AUDIO_BASE_DEF, 8'h00);
    settle(2);
    chk("wake state", 8'h17, st);
    chk("immediate restore", 8'h02, {6'h00, gpo});
    n = 0;
    while (general_output_a_o !== 1'b1 && n < 40) begin
      settle(1);
      n++;
    end
    chk("restore wait floor", 8'h01, {7'h00, n >= 2 * TICKS - 4});
    chk("restore wait cap", 8'h01, {7'h00, n <= 3 * TICKS + 2});
    pulse(0);
    rd(FLAG_PORT, 8'h38);
    rd(FLAG_PORT, 8'h08);
    // Partial power-down: offsets 4 and 5 stay quiet, the FM window wakes
    wr(CTRL_PORT, 8'hc8);
    wr(CTRL_PORT, 8'hcc);
    chk_st(8'h59, 2'b11);
    wr(CTRL_PORT, 8'hc8);
    wr(AUDIO_BASE_DEF + 12'h004, 8'h00);
    rd(AUDIO_BASE_DEF + 12'h005, 8'h00);
    chk_st(8'h59, 2'b11);
    rd(FM_BASE_DEF, 8'h00);
    chk_st(8'h17, 2'b11);
    rd(FLAG_PORT, 8'h68);
    // Crystal clock: partial still wakes, full does not
    @(posedge sys_clk_i);
    xtal_sel_i <= 1'b1;
    wr(CTRL_PORT, 8'hcc);
    chk_st(8'h59, 2'b11);
    pulse(2);
    chk_st(8'h17, 2'b11);
    wr(CTRL_PORT, 8'hc8);
    wr(CTRL_PORT, 8'hc4);
    chk_st(8'ha8, 2'b00);
    rd(AUDIO_BASE_DEF, 8'h00);
    pulse(1);
    chk_st(8'ha8, 2'b00);
    // Host forces the oscillator on while down; no new request edge
    wr(CTRL_PORT, 8'hd4);
    chk_st(8'hb8, 2'b00);
    // Soft reset leaves the output register alone
    @(posedge sys_clk_i);
    soft_rst_i <= 1'b1;
    @(posedge sys_clk_i);
    soft_rst_i <= 1'b0;
    settle(40);
    chk("soft reset state", 8'h17, st);
    chk("soft reset outputs", 8'h00, {6'h00, gpo});
    rd_opd(8'h72);
    // Oscillator clock: other activity wakes from full
    @(posedge sys_clk_i);
    xtal_sel_i <= 1'b0;
    wr(CTRL_PORT, 8'h04);
    chk_st(8'ha8, 2'b11);
    pulse(1);
    chk_st(8'h17, 2'b01);
    // Let the timed restore finish, then partial and a plain request to full
    settle(30);
    wr(CTRL_PORT, 8'h08);
    wr(CTRL_PORT, 8'h0c);
    chk_st(8'h59, 2'b00);
    wr(CTRL_PORT, 8'h08);
    wr(CTRL_PORT, 8'h04);
    chk_st(8'ha8, 2'b11);
    end_sim();
  end
endmodule
